// ===== src/sss_consts.vh
// Constants for the synchronous flow-through burst memory with select, stall and sleep.
// Included by every design file; holds definitions only.
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// ****************************************
// Array geometry
// ****************************************
`define SSS_ADDR_W 17
`define SSS_DATA_W 18
`define SSS_DEPTH 131072
`define SSS_BURST_W 2

// ****************************************
// Burst order input values
// ****************************************
`define SSS_MODE_LINEAR 1'b0
`define SSS_MODE_INTERLEAVED 1'b1

// ****************************************
// Register map (byte addresses) and fields
// ****************************************
`define SSS_REG_CTRL 4'h0
`define SSS_REG_STATUS 4'h4
`define SSS_REG_STALLS 4'h8
`define SSS_REG_WRITES 4'hc
`define SSS_CTRL_WR_EN_BIT 0
`define SSS_CTRL_RESET 32'h00000001
`define SSS_ST_SLEEP_BIT 0
`define SSS_ST_SEL_BIT 1
`define SSS_ST_STALL_BIT 2
`define SSS_ST_MODE_BIT 3
`define SSS_ST_WRPEND_BIT 4
`define SSS_ST_RDPEND_BIT 5

// ****************************************
// AXI responses
// ****************************************
`define SSS_RESP_OKAY 2'b00
`define SSS_RESP_SLVERR 2'b10

`endif

// ===== src/sss_burst.v
// Burst address sequencer: low address bits for a given beat.
// Assumes the caller holds the start bits and the order for the whole burst.
`timescale 1ns/100ps
`include "sss_consts.vh"

module sss_burst (
  input wire [`SSS_BURST_W-1:0] start_in, // Low bits of the loaded address
  input wire [`SSS_BURST_W-1:0] beat_in,  // Beat number within the burst
  input wire mode_in,                     // Burst order, linear or interleaved
  output reg [`SSS_BURST_W-1:0] low_out   // Low address bits for this beat
);

  always @* begin
    if (mode_in == `SSS_MODE_INTERLEAVED) begin
      low_out = start_in ^ beat_in;
    end else begin
      low_out = start_in + beat_in;
    end
  end

endmodule

// ===== src/sss_top.v
// Synchronous flow-through burst memory core with chip select, stall and sleep.
// Assumes controller pins change on the rising edge of mclk_in; registers over AXI4-Lite.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "sss_consts.vh"

module sss_top (
  input wire mclk_in,                          // Device clock, 20 MHz
  input wire reset_n_in,                       // Asynchronous reset, active low
  input wire chip_select_a_n_in,               // First select, active low
  input wire chip_select_b_in,                 // Second select, active high
  input wire chip_select_c_n_in,               // Third select, active low
  input wire clock_qualifier_n_in,             // Clock qualifier, active low
  input wire sleep_request_in,                 // Sleep request, active high
  input wire burst_mode_in,                    // Static burst order, 1 interleaved
  input wire advance_load_n_in,                // Low loads address, high advances
  input wire write_enable_n_in,                // Write when low at load
  input wire output_enable_n_in,               // Asynchronous output enable, low
  input wire [`SSS_ADDR_W-1:0] addr_in,        // Memory address
  input wire [`SSS_DATA_W-1:0] dq_in,          // Data pin input level
  output wire [`SSS_DATA_W-1:0] dq_out,        // Data pin drive value
  output wire dq_oe_out,                       // Data pin drive enable
  input wire [3:0] s_axi_awaddr_in,            // AXI write address
  input wire s_axi_awvalid_in,                 // AXI write address valid
  output wire s_axi_awready_out,               // AXI write address ready
  input wire [31:0] s_axi_wdata_in,            // AXI write data
  input wire [3:0] s_axi_wstrb_in,             // AXI write strobes
  input wire s_axi_wvalid_in,                  // AXI write data valid
  output wire s_axi_wready_out,                // AXI write data ready
  output wire [1:0] s_axi_bresp_out,           // AXI write response
  output wire s_axi_bvalid_out,                // AXI write response valid
  input wire s_axi_bready_in,                  // AXI write response ready
  input wire [3:0] s_axi_araddr_in,            // AXI read address
  input wire s_axi_arvalid_in,                 // AXI read address valid
  output wire s_axi_arready_out,               // AXI read address ready
  output wire [31:0] s_axi_rdata_out,          // AXI read data
  output wire [1:0] s_axi_rresp_out,           // AXI read response
  output wire s_axi_rvalid_out,                // AXI read data valid
  input wire s_axi_rready_in                   // AXI read data ready
);

  // ****************************************
  // Operation states
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_READ = 4'h2;
  localparam [3:0] ST_WRITE = 4'h4;
  localparam [3:0] ST_SLEEP = 4'h8;
  // Only the array write enable bit of the control word is writable
  localparam [31:0] CTRL_WMASK = 32'h00000001 << `SSS_CTRL_WR_EN_BIT;

  reg [`SSS_DATA_W-1:0] mem_r [0:`SSS_DEPTH-1];
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [`SSS_ADDR_W-1:0] base_r;
  reg [`SSS_ADDR_W-1:0] base_nxt;
  reg [`SSS_BURST_W-1:0] beat_r;
  reg [`SSS_BURST_W-1:0] beat_nxt;
  reg mode_r;
  reg mode_nxt;
  reg [`SSS_ADDR_W-1:0] addr_r;
  reg [`SSS_DATA_W-1:0] rd_data_r;
  reg drive_r;
  reg sel_seen_r;
  reg stall_seen_r;
  reg [31:0] ctrl_r;
  reg [31:0] stalls_r;
  reg [31:0] writes_r;
  wire selected;
  wire qualified;
  wire array_write;
  wire [`SSS_BURST_W-1:0] low_nxt;
  wire [`SSS_ADDR_W-1:0] addr_nxt;

  // ****************************************
  // Select and qualifier decode
  // ****************************************
  // Composite select
  assign selected = ~chip_select_a_n_in & chip_select_b_in & ~chip_select_c_n_in;
  assign qualified = ~clock_qualifier_n_in;

  // ****************************************
  // Next operation decode
  // ****************************************
  always @* begin
    state_nxt = state_r;
    base_nxt = base_r;
    beat_nxt = beat_r;
    mode_nxt = mode_r;
    if (!advance_load_n_in) begin
      beat_nxt = {`SSS_BURST_W{1'b0}};
      base_nxt = addr_in;
      mode_nxt = burst_mode_in;
      if (selected) begin
        state_nxt = write_enable_n_in ? ST_READ : ST_WRITE;
      end else begin
        state_nxt = ST_IDLE;
      end
    end else begin
      case (state_r)
        ST_READ, ST_WRITE: begin
          beat_nxt = beat_r + {{(`SSS_BURST_W-1){1'b0}}, 1'b1};
        end
        ST_IDLE, ST_SLEEP: begin
          state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  sss_burst u_burst (
    .start_in(base_nxt[`SSS_BURST_W-1:0]),
    .beat_in(beat_nxt),
    .mode_in(mode_nxt),
    .low_out(low_nxt)
  );

  assign addr_nxt = {base_nxt[`SSS_ADDR_W-1:`SSS_BURST_W], low_nxt};

  assign array_write = qualified & ~sleep_request_in & (state_r == ST_WRITE) &
                       ctrl_r[`SSS_CTRL_WR_EN_BIT];

  // ****************************************
  // Operation pipeline
  // ****************************************
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      base_r <= {`SSS_ADDR_W{1'b0}};
      beat_r <= {`SSS_BURST_W{1'b0}};
      mode_r <= `SSS_MODE_LINEAR;
      addr_r <= {`SSS_ADDR_W{1'b0}};
      rd_data_r <= {`SSS_DATA_W{1'b0}};
      drive_r <= 1'b0;
      sel_seen_r <= 1'b0;
      stall_seen_r <= 1'b0;
    end else if (sleep_request_in) begin
      state_r <= ST_SLEEP;
      drive_r <= 1'b0;
    end else if (qualified) begin
      stall_seen_r <= 1'b0;
      sel_seen_r <= selected;
      state_r <= state_nxt;
      base_r <= base_nxt;
      beat_r <= beat_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      rd_data_r <= mem_r[addr_nxt];
      drive_r <= (state_nxt == ST_READ) & (state_r != ST_SLEEP);
    end else begin
      stall_seen_r <= 1'b1;
    end
  end

  // ****************************************
  // Memory array
  // ****************************************
  always @(posedge mclk_in) begin
    if (array_write) begin
      mem_r[addr_r] <= dq_in;
    end
  end

  assign dq_out = rd_data_r;
  assign dq_oe_out = drive_r & ~output_enable_n_in;

  // ****************************************
  // Register slave
  // ****************************************
  function [2:0] reg_decode;
    input [3:0] addr;
    begin
      case (addr)
        `SSS_REG_CTRL: reg_decode = 3'h4;
        `SSS_REG_STATUS: reg_decode = 3'h5;
        `SSS_REG_STALLS: reg_decode = 3'h6;
        `SSS_REG_WRITES: reg_decode = 3'h7;
        default: reg_decode = 3'h0;
      endcase
    end
  endfunction

  reg aw_full_r;
  reg w_full_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  reg [31:0] status_w;
  reg [31:0] rd_mux;
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  wire wr_go;
  integer i;

  assign s_axi_awready_out = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready_out = ~w_full_r & ~bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = ~rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;
  assign wr_dec = reg_decode(awaddr_r);
  assign rd_dec = reg_decode(s_axi_araddr_in);
  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;

  always @* begin
    status_w = 32'h00000000;
    status_w[`SSS_ST_SLEEP_BIT] = (state_r == ST_SLEEP);
    status_w[`SSS_ST_SEL_BIT] = sel_seen_r;
    status_w[`SSS_ST_STALL_BIT] = stall_seen_r;
    status_w[`SSS_ST_MODE_BIT] = mode_r;
    status_w[`SSS_ST_WRPEND_BIT] = (state_r == ST_WRITE);
    status_w[`SSS_ST_RDPEND_BIT] = (state_r == ST_READ);
    case (rd_dec[1:0])
      2'h0: rd_mux = ctrl_r;
      2'h1: rd_mux = status_w;
      2'h2: rd_mux = stalls_r;
      default: rd_mux = writes_r;
    endcase
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `SSS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `SSS_RESP_OKAY;
      rdata_r <= 32'h00000000;
      ctrl_r <= `SSS_CTRL_RESET;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_dec[2] ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
        if (wr_dec == 3'h4) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (wstrb_r[i]) begin
              ctrl_r[i*8 +: 8] <= wdata_r[i*8 +: 8] & CTRL_WMASK[i*8 +: 8];
            end
          end
        end
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
      if (s_axi_arvalid_in && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_dec[2] ? rd_mux : 32'h00000000;
        rresp_r <= rd_dec[2] ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Event counters
  // ****************************************
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stalls_r <= 32'h00000000;
      writes_r <= 32'h00000000;
    end else begin
      if (!qualified && !sleep_request_in) begin
        stalls_r <= stalls_r + 32'h00000001;
      end
      if (array_write) begin
        writes_r <= writes_r + 32'h00000001;
      end
    end
  end

endmodule

// ===== test/sss_chk.sv
// Pin and register bus checker for the select, stall and sleep memory core.
// Assumes one clock domain and the asynchronous active-low reset of the core.
`timescale 1ns/100ps
module sss_chk (
  input wire mclk_in, // Clock
  input wire reset_n_in, // Reset, active low
  input wire chip_select_a_n_in, // First select
  input wire chip_select_b_in, // Second select
  input wire chip_select_c_n_in, // Third select
  input wire clock_qualifier_n_in, // Clock qualifier
  input wire sleep_request_in, // Sleep request
  input wire advance_load_n_in, // Load or advance
  input wire write_enable_n_in, // Write enable
  input wire output_enable_n_in, // Output enable
  input wire [17:0] dq_out, // Read data
  input wire dq_oe_out, // Drive enable
  input wire s_axi_awready_out, // Write address ready
  input wire s_axi_wready_out, // Write data ready
  input wire s_axi_bvalid_out, // Write response valid
  input wire s_axi_arvalid_in, // Read address valid
  input wire s_axi_arready_out, // Read address ready
  input wire s_axi_rvalid_out // Read data valid
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire sel = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
  wire go = !clock_qualifier_n_in && !sleep_request_in && !advance_load_n_in;
  reg slept_r = 1'b0;
  // Sleep seen since the last qualified edge, stalls included
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slept_r <= 1'b0;
    end else if (sleep_request_in) begin
      slept_r <= 1'b1;
    end else if (!clock_qualifier_n_in) begin
      slept_r <= 1'b0;
    end
  end
  sel_read_a: assert property (go && sel && write_enable_n_in && !slept_r
    |=> dq_oe_out || output_enable_n_in) else $error("selected read not driven");
  desel_idle_a: assert property (go && !sel |=> !dq_oe_out)
    else $error("deselected load drives");
  stall_hold_a: assert property (clock_qualifier_n_in && !sleep_request_in |=> $stable(dq_out))
    else $error("read data moved in stall");
  stall_oe_a: assert property (clock_qualifier_n_in && !sleep_request_in
    && !output_enable_n_in ##1 !output_enable_n_in |-> $stable(dq_oe_out))
    else $error("drive changed in stall");
  sleep_off_a: assert property (sleep_request_in |=> !dq_oe_out)
    else $error("drives while asleep");
  wake_quiet_a: assert property ($fell(sleep_request_in) && $past(reset_n_in) |=> !dq_oe_out)
    else $error("drives on leaving sleep");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken during response");
  aw_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
endmodule
bind sss_top sss_chk u_sss_chk (.*);

// ===== test/sss_ctrl_model.sv
// Behavioural memory controller driving selects, qualifier, sleep, mode and data.
// Assumes the bench calls cyc once per clock; pins change just after each rising edge.
`timescale 1ns/100ps
module sss_ctrl_model (
  input wire mclk_in, // Device clock
  input wire [17:0] dq_in, // Device data value
  input wire dq_oe_in, // Device drive enable
  output reg [2:0] sel_out = 3'b110, // Selects a_n, b, c_n
  output reg cq_n_out = 1'b0, // Clock qualifier
  output reg sleep_out = 1'b0, // Sleep request
  output reg mode_out = 1'b0, // Burst order
  output reg adv_n_out = 1'b0, // Load low, advance high
  output reg we_n_out = 1'b1, // Write when low
  output reg [16:0] addr_out = 17'h0, // Address
  output wire [17:0] dq_pin_out // Resolved data line
);
  reg [17:0] wd_r = 18'h0;
  reg wdrv_r = 1'b0;
  reg [17:0] last_r = 18'h0;
  // Released line shows the inverse of its last level
  assign dq_pin_out = wdrv_r ? wd_r : (dq_oe_in ? dq_in : ~last_r);
  always @(posedge mclk_in) last_r <= dq_pin_out;
  // Stall on request; sleep only raised while deselected
  task cyc(input [2:0] s, input st, input ld, input we, input [16:0] a,
    input [17:0] d, input dr, input z);
    begin
      @(posedge mclk_in);
      sel_out <= s;
      cq_n_out <= st;
      adv_n_out <= ld;
      we_n_out <= we;
      addr_out <= a;
      wd_r <= d;
      wdrv_r <= dr;
      sleep_out <= z;
    end
  endtask
  // Burst order changed only between bursts
  task set_mode(input m);
    begin
      @(posedge mclk_in);
      mode_out <= m;
    end
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench: memory pin sequences and register bus accesses.
// Assumes the controller model and the checker bound to the core.
`timescale 1ns/100ps
module tb_top;
  reg mclk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg [3:0] awaddr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] araddr = 4'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, cq_n, slp, mode, adv_n, we_n, dqe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] sel;
  wire [16:0] addr;
  wire [17:0] dqi, dqo;
  integer fails = 0;
  integer checked = 0;
  integer i;
  reg [31:0] rv;
  reg [31:0] wcnt;
  reg [1:0] rr;
  localparam [2:0] on = 3'b010;
  localparam [2:0] off = 3'b110;
  sss_top u_sss_top (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .chip_select_a_n_in(sel[2]),
    .chip_select_b_in(sel[1]), .chip_select_c_n_in(sel[0]), .clock_qualifier_n_in(cq_n),
    .sleep_request_in(slp), .burst_mode_in(mode), .advance_load_n_in(adv_n),
    .write_enable_n_in(we_n), .output_enable_n_in(1'b0), .addr_in(addr), .dq_in(dqi),
    .dq_out(dqo), .dq_oe_out(dqe), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  sss_ctrl_model u_m (.mclk_in(mclk_in), .dq_in(dqo), .dq_oe_in(dqe), .sel_out(sel),
    .cq_n_out(cq_n), .sleep_out(slp), .mode_out(mode), .adv_n_out(adv_n), .we_n_out(we_n),
    .addr_out(addr), .dq_pin_out(dqi));
  initial forever #25 mclk_in = ~mclk_in;
  task close_out;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  function [17:0] pat(input [16:0] a);
    pat = {1'b0, a} ^ 18'h2aaaa;
  endfunction
  task wr(input [16:0] a, input [17:0] d);
    begin
      u_m.cyc(on, 0, 0, 0, a, 0, 0, 0);
      u_m.cyc(off, 0, 0, 1, 0, d, 1, 0);
    end
  endtask
  task rd(input [16:0] a, input [17:0] e);
    begin
      u_m.cyc(on, 0, 0, 1, a, 0, 0, 0);
      u_m.cyc(off, 0, 0, 1, 0, 0, 0, 0);
      #1;
      chk({14'h0, dqo}, {14'h0, e});
      chk({31'h0, dqe}, 32'h1);
    end
  endtask
  task axi_wr(input [3:0] a, input [31:0] d);
    reg done;
    begin
      done = 1'b0;
      @(posedge mclk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
        @(posedge mclk_in);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          chk({30'h0, bresp}, 32'h0);
          done = 1'b1;
        end
      end
    end
  endtask
  task axi_rd(input [3:0] a);
    reg done;
    begin
      done = 1'b0;
      @(posedge mclk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
        @(posedge mclk_in);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          rv = rdata;
          rr = rresp;
          done = 1'b1;
        end
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    axi_rd(4'h0);
    chk(rv, 32'h1);
    chk({30'h0, rr}, 32'h0);
    for (i = 0; i < 4; i = i + 1) wr(17'h20 + i[16:0], pat(17'h20 + i[16:0]));
    rd(17'h20, pat(17'h20));
    for (i = 0; i < 3; i = i + 1) begin
      u_m.cyc(on ^ (3'b100 >> i), 0, 0, 1, 17'h20, 0, 0, 0);
      u_m.cyc(off, 0, 0, 1, 0, 0, 0, 0);
      #1;
      chk({31'h0, dqe}, 32'h0);
    end
    for (i = 0; i < 2; i = i + 1) begin
      u_m.set_mode(i[0]);
      u_m.cyc(on, 0, 0, 1, 17'h21, 0, 0, 0);
      u_m.cyc(on, 0, 1, 1, 0, 0, 0, 0);
      u_m.cyc(off, 0, 0, 1, 0, 0, 0, 0);
      #1;
      chk({14'h0, dqo}, {14'h0, pat(i ? 17'h20 : 17'h22)});
    end
    u_m.cyc(on, 0, 0, 1, 17'h23, 0, 0, 0);
    u_m.cyc(off, 1, 0, 1, 0, 0, 0, 0);
    u_m.cyc(off, 0, 0, 1, 0, 0, 0, 0);
    #1;
    chk({14'h0, dqo}, {14'h0, pat(17'h23)});
    chk({31'h0, dqe}, 32'h1);
    axi_rd(4'hc);
    chk(rv, 32'h4);
    wcnt = rv;
    u_m.cyc(on, 0, 0, 0, 17'h30, 0, 0, 0);
    u_m.cyc(off, 1, 0, 1, 0, 18'h3f00f, 1, 0);
    u_m.cyc(off, 0, 0, 1, 0, pat(17'h30), 1, 0);
    rd(17'h30, pat(17'h30));
    axi_rd(4'hc);
    chk(rv, wcnt + 32'h1);
    axi_rd(4'h8);
    chk(rv, 32'h2);
    u_m.cyc(off, 0, 0, 1, 0, 0, 0, 1);
    u_m.cyc(off, 0, 0, 1, 0, 0, 0, 1);
    #1;
    chk({31'h0, dqe}, 32'h0);
    axi_rd(4'h4);
    chk(rv & 32'h1, 32'h1);
    u_m.cyc(on, 0, 0, 1, 17'h20, 0, 0, 0);
    u_m.cyc(off, 0, 0, 1, 0, 0, 0, 0);
    #1;
    chk({31'h0, dqe}, 32'h0);
    rd(17'h20, pat(17'h20));
    axi_wr(4'h0, 32'h0);
    wr(17'h21, ~pat(17'h21));
    axi_wr(4'h0, 32'h1);
    rd(17'h21, pat(17'h21));
    axi_rd(4'h2);
    chk(rv, 32'h0);
    chk({30'h0, rr}, 32'h2);
    close_out;
  end
  initial begin
    #100000;
    fails = fails + 1;
    close_out;
  end
endmodule
